// [core/msecr_pkg.sv]
// Shared constants and types for the switch and error-config register block
package msecr_pkg;

    // ==========================================================
    // Register map
    localparam logic [6:0] MSECR_ADDR_SWITCH   = 7'h01;
    localparam logic [6:0] MSECR_ADDR_ERRCFG   = 7'h02;
    localparam logic [7:0] MSECR_SWITCH_RESET  = 8'h00;
    localparam logic [7:0] MSECR_ERRCFG_RESET  = 8'h06;
    localparam logic [7:0] MSECR_SWITCH_WMASK8 = 8'hff;
    localparam logic [7:0] MSECR_SWITCH_WMASK4 = 8'hf7;
    localparam logic [7:0] MSECR_ERRCFG_WMASK  = 8'h07;

    // ==========================================================
    // Field positions
    localparam int MSECR_SW_EN_BIT     = 0;
    localparam int MSECR_SW_SEL_LSB    = 1;
    localparam int MSECR_SW_RSV_BIT    = 3;
    localparam int MSECR_SW_GPO_LSB    = 4;
    localparam int MSECR_GPO_COUNT     = 4;
    localparam int MSECR_CFG_CRC_BIT   = 0;
    localparam int MSECR_CFG_SCLK_BIT  = 1;
    localparam int MSECR_CFG_ADDR_BIT  = 2;
    localparam int MSECR_CFG_RSV_LSB   = 3;
    localparam int MSECR_CFG_RSV_W     = 5;

    // ==========================================================
    // Frame layout
    localparam int         MSECR_RW_BIT           = 7;
    localparam int         MSECR_ADDR_W           = 7;
    localparam logic [1:0] MSECR_WORD_BYTES_PLAIN = 2'h2;
    localparam logic [1:0] MSECR_WORD_BYTES_CRC   = 2'h3;
    localparam logic [4:0] MSECR_TX_BITS          = 5'h10;
    localparam logic [7:0] MSECR_CRC_INIT         = 8'h00;

    // ==========================================================
    // Timing
    localparam int MSECR_CLK_PERIOD_NS = 10;
    localparam int MSECR_DRAIN_TIME_NS = 60;
    localparam int MSECR_DRAIN_CYC     =
        (MSECR_DRAIN_TIME_NS + MSECR_CLK_PERIOD_NS - 1) / MSECR_CLK_PERIOD_NS;

    // ==========================================================
    // Frame sequencer states
    typedef enum logic [3:0] {
        ST_IDLE   = 4'h1,
        ST_RECV   = 4'h2,
        ST_DRAIN  = 4'h4,
        ST_COMMIT = 4'h8
    } msecr_state_t;

endpackage : msecr_pkg

// [core/msecr_sync.sv]
// Two-flop level synchroniser into the reference clock domain
module msecr_sync
    import msecr_pkg::*;
#(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    // ==========================================================
    // Sync chain
    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= RESET_VAL;
            q      <= RESET_VAL;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule : msecr_sync

// [core/msecr_link.sv]
// Serial link front end, clocked by the host serial clock
module msecr_link
    import msecr_pkg::*;
(
    input  wire logic        spi_sclk,
    input  wire logic        arst_n,
    input  wire logic        spi_cs_n,
    input  wire logic        spi_mosi,
    input  wire logic [15:0] tx_word,
    output logic      [7:0]  rx_byte_q,
    output logic             rx_tgl_q,
    output logic      [2:0]  bit_cnt_q,
    output logic             miso_q
);

    // ==========================================================
    // Frame tracking
    logic       frame_rst_n;
    logic       started_q;
    logic [4:0] fcnt_q;
    logic [7:0] shift_q;
    logic [2:0] bit_cnt_d;
    logic [4:0] fcnt_d;
    logic [7:0] shift_d;

    // Chip select high clears the start flag; serial clock may be stopped then
    assign frame_rst_n = arst_n & ~spi_cs_n;

    always_comb begin
        bit_cnt_d = started_q ? bit_cnt_q + 3'h1 : 3'h1;
        fcnt_d    = !started_q ? 5'h01 : ((fcnt_q == 5'h1f) ? fcnt_q : fcnt_q + 5'h01);
        shift_d   = {shift_q[6:0], spi_mosi};
    end

    always_ff @(posedge spi_sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            started_q <= 1'b0;
        end else begin
            started_q <= 1'b1;
        end
    end

    // Counts survive chip select so the leftover stays readable afterwards
    always_ff @(posedge spi_sclk or negedge arst_n) begin
        if (!arst_n) begin
            bit_cnt_q <= 3'h0;
            fcnt_q    <= 5'h00;
            shift_q   <= 8'h00;
        end else begin
            bit_cnt_q <= bit_cnt_d;
            fcnt_q    <= fcnt_d;
            shift_q   <= shift_d;
        end
    end

    // ==========================================================
    // Byte hand-off by toggle
    always_ff @(posedge spi_sclk or negedge arst_n) begin
        if (!arst_n) begin
            rx_byte_q <= 8'h00;
            rx_tgl_q  <= 1'b0;
        end else if (bit_cnt_d == 3'h0) begin
            rx_byte_q <= shift_d;
            rx_tgl_q  <= ~rx_tgl_q;
        end
    end

    AST_BYTE_EVERY_EIGHT: assert property (
        @(posedge spi_sclk) disable iff (!arst_n)
        $changed(rx_tgl_q) |-> (bit_cnt_q == 3'h0)
    ) else $error("byte hand-off off the byte boundary");

    // ==========================================================
    // Readback, one bit behind the host sampling edge
    always_ff @(negedge spi_sclk or negedge arst_n) begin
        if (!arst_n) begin
            miso_q <= 1'b0;
        end else if (!started_q || fcnt_q >= MSECR_TX_BITS) begin
            miso_q <= 1'b0;
        end else begin
            miso_q <= tx_word[4'(MSECR_TX_BITS - fcnt_q)];
        end
    end

endmodule : msecr_link

// [core/msecr_top.sv]
// Switch control and error configuration registers behind a serial link
//
// How it works
// - Switch control register at 0x01 resets to 0x00, switches off, outputs low.
// - Bits 7..4 drive general outputs four..one directly.
// - Bit 0 is master enable; cleared means every switch open.
// - Eight-channel build: code n in bits 3..1 closes switch n+1.
// - Four-pair build: code n in bits 2..1 closes pair n+1.
// - Four-pair build: bit 3 reads zero and ignores writes.
// - Error config register at 0x02 resets to 0x06.
// - Error config bits 7..3 read zero, writes ignored.
// - Error config bit 2 enables invalid address detection, default one.
// - Error config bit 1 enables serial clock count checking.
// - Without burst, frames must carry exactly 16 or 24 clocks.
// - With burst, frames must carry a whole multiple of 16 or 24.
// - Error config bit 0 enables CRC and stretches words to 24 bits.
// - Burst lets several commands share one chip select, each processed.
// - Round robin mode forces all general outputs low.
module msecr_top
    import msecr_pkg::*;
#(
    parameter int         NUM_SWITCH = 8,
    parameter logic [7:0] CRC_POLY   = 8'h07
) (
    input  wire logic                  ref_clk,
    input  wire logic                  arst_n,
    input  wire logic                  spi_sclk,
    input  wire logic                  spi_cs_n,
    input  wire logic                  spi_mosi,
    input  wire logic                  burst_mode,
    input  wire logic                  round_robin_active,
    output logic                       spi_miso,
    output logic      [NUM_SWITCH-1:0] channel_switch,
    output logic                       general_output_one,
    output logic                       general_output_two,
    output logic                       general_output_three,
    output logic                       general_output_four,
    output logic                       addr_err_pulse,
    output logic                       sclk_err_pulse,
    output logic                       crc_err_pulse
);

    // ==========================================================
    // Elaboration checks
    localparam int SEL_W   = $clog2(NUM_SWITCH);
    localparam int DRAIN_W = $clog2(MSECR_DRAIN_CYC + 1);

    if (NUM_SWITCH != 8 && NUM_SWITCH != 4) begin : g_bad_switch_count
        $error("NUM_SWITCH must be 8 or 4");
    end

    // ==========================================================
    // Link domain and crossings
    logic [7:0]   rx_byte;
    logic         rx_tgl;
    logic [2:0]   link_bit_cnt;
    logic         cs_n_s;
    logic         tgl_s;
    logic         tgl_prev_q;
    logic [15:0]  tx_word_q;

    // Readback word is only updated at frame commit, after chip select is seen high
    msecr_link u_link (
        .spi_sclk  (spi_sclk),
        .arst_n    (arst_n),
        .spi_cs_n  (spi_cs_n),
        .spi_mosi  (spi_mosi),
        .tx_word   (tx_word_q),
        .rx_byte_q (rx_byte),
        .rx_tgl_q  (rx_tgl),
        .bit_cnt_q (link_bit_cnt),
        .miso_q    (spi_miso)
    );

    msecr_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_cs_sync (
        .clk    (ref_clk),
        .arst_n (arst_n),
        .d      (spi_cs_n),
        .q      (cs_n_s)
    );

    msecr_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_tgl_sync (
        .clk    (ref_clk),
        .arst_n (arst_n),
        .d      (rx_tgl),
        .q      (tgl_s)
    );

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tgl_prev_q <= 1'b0;
        end else begin
            tgl_prev_q <= tgl_s;
        end
    end

    // ==========================================================
    // Frame sequencer
    msecr_state_t       state_q;
    logic [DRAIN_W-1:0] drain_q;
    logic               in_commit;

    assign in_commit = (state_q == ST_COMMIT);

    // Drain lets the last byte toggle land before the frame is judged
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_IDLE;
            drain_q <= '0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (!cs_n_s) begin
                        state_q <= ST_RECV;
                    end
                end
                ST_RECV: begin
                    drain_q <= '0;
                    if (cs_n_s) begin
                        state_q <= ST_DRAIN;
                    end
                end
                ST_DRAIN: begin
                    drain_q <= drain_q + DRAIN_W'(1);
                    if (drain_q == DRAIN_W'(MSECR_DRAIN_CYC - 1)) begin
                        state_q <= ST_COMMIT;
                    end
                end
                ST_COMMIT: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Word assembly and decode
    logic [7:0]  sw_q;
    logic [7:0]  cfg_q;
    logic [7:0]  wb0_q;
    logic [7:0]  wb1_q;
    logic [1:0]  byte_idx_q;
    logic [7:0]  words_q;
    logic        crc_on;
    logic [1:0]  word_bytes;
    logic        byte_evt;
    logic        word_end;
    logic        take;
    logic [7:0]  data_b;
    logic        crc_ok;
    logic        is_read;
    logic [6:0]  cmd_addr;
    logic        addr_ok;
    logic        count_ok;
    logic        frame_ok;
    logic [7:0]  sw_wmask;

    function automatic logic [7:0] msecr_crc8(input logic [15:0] data);
        logic [7:0] crc;
        crc = MSECR_CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            crc = (crc[7] ^ data[i]) ? ({crc[6:0], 1'b0} ^ CRC_POLY) : {crc[6:0], 1'b0};
        end
        return crc;
    endfunction : msecr_crc8

    always_comb begin
        crc_on     = cfg_q[MSECR_CFG_CRC_BIT];
        word_bytes = crc_on ? MSECR_WORD_BYTES_CRC : MSECR_WORD_BYTES_PLAIN;
        byte_evt   = (tgl_s != tgl_prev_q) && (state_q == ST_RECV || state_q == ST_DRAIN);
        word_end   = byte_evt && (byte_idx_q == word_bytes - 2'h1);
        take       = word_end && (burst_mode || words_q == 8'h00);
        data_b     = crc_on ? wb1_q : rx_byte;
        crc_ok     = !crc_on || (msecr_crc8({wb0_q, data_b}) == rx_byte);
        is_read    = wb0_q[MSECR_RW_BIT];
        cmd_addr   = wb0_q[MSECR_ADDR_W-1:0];
        addr_ok    = (cmd_addr == MSECR_ADDR_SWITCH) || (cmd_addr == MSECR_ADDR_ERRCFG);
        // Whole words only, leftover clocks count as a bad frame
        count_ok   = (link_bit_cnt == 3'h0) && (byte_idx_q == 2'h0)
                   && (burst_mode ? (words_q != 8'h00) : (words_q == 8'h01));
        frame_ok   = !cfg_q[MSECR_CFG_SCLK_BIT] || count_ok;
        sw_wmask   = (NUM_SWITCH == 8) ? MSECR_SWITCH_WMASK8 : MSECR_SWITCH_WMASK4;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wb0_q      <= 8'h00;
            wb1_q      <= 8'h00;
            byte_idx_q <= 2'h0;
            words_q    <= 8'h00;
        end else if (state_q == ST_IDLE) begin
            byte_idx_q <= 2'h0;
            words_q    <= 8'h00;
        end else if (byte_evt) begin
            if (byte_idx_q == 2'h0) begin
                wb0_q <= rx_byte;
            end
            if (byte_idx_q == 2'h1) begin
                wb1_q <= rx_byte;
            end
            if (word_end) begin
                byte_idx_q <= 2'h0;
                words_q    <= (words_q == 8'hff) ? words_q : words_q + 8'h01;
            end else begin
                byte_idx_q <= byte_idx_q + 2'h1;
            end
        end
    end

    // ==========================================================
    // Staged writes and readback
    logic [7:0]  pend_sw_q;
    logic [7:0]  pend_cfg_q;
    logic        pend_sw_v_q;
    logic        pend_cfg_v_q;
    logic [15:0] pend_tx_q;
    logic        pend_tx_v_q;

    // Later commands in a burst overwrite earlier ones
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pend_sw_q    <= MSECR_SWITCH_RESET;
            pend_cfg_q   <= MSECR_ERRCFG_RESET;
            pend_sw_v_q  <= 1'b0;
            pend_cfg_v_q <= 1'b0;
            pend_tx_q    <= 16'h0000;
            pend_tx_v_q  <= 1'b0;
        end else if (state_q == ST_IDLE) begin
            pend_sw_v_q  <= 1'b0;
            pend_cfg_v_q <= 1'b0;
            pend_tx_v_q  <= 1'b0;
        end else if (take && crc_ok && addr_ok) begin
            if (is_read) begin
                pend_tx_q   <= {cmd_addr, (cmd_addr == MSECR_ADDR_SWITCH) ? sw_q : cfg_q, 1'b0};
                pend_tx_v_q <= 1'b1;
            end else if (cmd_addr == MSECR_ADDR_SWITCH) begin
                pend_sw_q   <= data_b & sw_wmask;
                pend_sw_v_q <= 1'b1;
            end else begin
                pend_cfg_q   <= data_b & MSECR_ERRCFG_WMASK;
                pend_cfg_v_q <= 1'b1;
            end
        end
    end

    // Nothing reaches the live registers before the frame is judged
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sw_q      <= MSECR_SWITCH_RESET;
            cfg_q     <= MSECR_ERRCFG_RESET;
            tx_word_q <= 16'h0000;
        end else if (in_commit && frame_ok) begin
            if (pend_sw_v_q) begin
                sw_q <= pend_sw_q;
            end
            if (pend_cfg_v_q) begin
                cfg_q <= pend_cfg_q;
            end
            if (pend_tx_v_q) begin
                tx_word_q <= pend_tx_q;
            end
        end
    end

    // ==========================================================
    // Error pulses
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_err_pulse <= 1'b0;
            sclk_err_pulse <= 1'b0;
            crc_err_pulse  <= 1'b0;
        end else begin
            addr_err_pulse <= take && crc_ok && !addr_ok && cfg_q[MSECR_CFG_ADDR_BIT];
            sclk_err_pulse <= in_commit && cfg_q[MSECR_CFG_SCLK_BIT] && !count_ok;
            crc_err_pulse  <= take && !crc_ok;
        end
    end

    // ==========================================================
    // Switch decode and general outputs
    logic [SEL_W-1:0]           sel;
    logic [MSECR_GPO_COUNT-1:0] gpo_q;

    assign sel = sw_q[MSECR_SW_SEL_LSB +: SEL_W];

    for (genvar g = 0; g < NUM_SWITCH; g++) begin : g_switch
        always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
                channel_switch[g] <= 1'b0;
            end else begin
                channel_switch[g] <= sw_q[MSECR_SW_EN_BIT] && (sel == SEL_W'(g));
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            gpo_q <= '0;
        end else if (round_robin_active) begin
            gpo_q <= '0;
        end else begin
            gpo_q <= sw_q[MSECR_SW_GPO_LSB +: MSECR_GPO_COUNT];
        end
    end

    assign general_output_one   = gpo_q[0];
    assign general_output_two   = gpo_q[1];
    assign general_output_three = gpo_q[2];
    assign general_output_four  = gpo_q[3];

    // ==========================================================
    // Checks
    AST_SWITCH_NEEDS_EN: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        (|channel_switch) |-> $past(sw_q[MSECR_SW_EN_BIT])
    ) else $error("switch closed while master enable clear");

    AST_SWITCH_CODE: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        $past(sw_q[MSECR_SW_EN_BIT]) |-> (channel_switch == (NUM_SWITCH'(1) << $past(sel)))
    ) else $error("closed switch does not match select code");

    AST_SWITCH_ONEHOT: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        $onehot0(channel_switch)
    ) else $error("more than one switch closed");

    AST_GPO_FOLLOW: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        !$past(round_robin_active) |-> (gpo_q == $past(sw_q[MSECR_SW_GPO_LSB +: MSECR_GPO_COUNT]))
    ) else $error("general outputs do not follow register bits");

    AST_GPO_ROUND_ROBIN: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        round_robin_active |=> (gpo_q == '0)
    ) else $error("general outputs not low in round robin");

    AST_SW_RESERVED: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        (NUM_SWITCH == 4) |-> !sw_q[MSECR_SW_RSV_BIT]
    ) else $error("reserved switch bit set");

    AST_CFG_RESERVED: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        cfg_q[MSECR_CFG_RSV_LSB +: MSECR_CFG_RSV_W] == '0
    ) else $error("reserved config bits set");

    AST_COMMIT_ONLY: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        $changed(sw_q) |-> $past(in_commit)
    ) else $error("switch register changed outside frame commit");

    AST_BAD_FRAME_HOLD: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        (in_commit && cfg_q[MSECR_CFG_SCLK_BIT] && !count_ok)
            |=> ($stable(sw_q) && $stable(cfg_q) && sclk_err_pulse)
    ) else $error("bad clock count frame not rejected");

    AST_SCLK_FLAG_EN: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        sclk_err_pulse |-> $past(cfg_q[MSECR_CFG_SCLK_BIT])
    ) else $error("clock count flagged while check disabled");

    AST_ADDR_FLAG_EN: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        addr_err_pulse |-> $past(cfg_q[MSECR_CFG_ADDR_BIT])
    ) else $error("address error flagged while check disabled");

    AST_CRC_REJECT: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        (take && !crc_ok) |=> (crc_err_pulse && $stable(pend_sw_q) && $stable(pend_cfg_q))
    ) else $error("word with bad CRC not rejected");

endmodule : msecr_top

// [verif/msecr_host.sv]
// Serial host model driving register frames into the block
module msecr_host (
    output logic      sclk,
    output logic      cs_n,
    output logic      mosi,
    input  wire logic miso
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // Frame driver
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // Clock stands low between frames; idle data flips so no stale value
    task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] rd);
        rd   = '0;
        #3.1 cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            mosi = w[i];
            #7.5 sclk = 1'b1;
            rd   = {rd[30:0], miso};
            #7.5 sclk = 1'b0;
        end
        #7.5 cs_n = 1'b1;
        mosi = ~mosi;
        #160; // Drain and commit need the gap
    endtask : xfer
endmodule : msecr_host

// [verif/test_mux_switch_error_config_regs.sv]
// Self-checking bench for the switch and error-config register block
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); end end
module test_mux_switch_error_config_regs;
    timeunit 1ns;
    timeprecision 100ps;
    logic        ref_clk = 1'b0, arst_n = 1'b0, burst_mode = 1'b0, rr = 1'b0;
    logic        sclk, cs_n, mosi, miso, a_p, s_p, c_p;
    logic [7:0]  ch, sw, d;
    logic [3:0]  gpo;
    logic [31:0] r;
    int          mismatches = 0, check_count = 0, n_a = 0, n_s = 0, n_c = 0;
    int          seed = 32'hb087_ddf1;
    // Frame check polynomial chosen for this block, init zero, MSB first
    localparam logic [7:0] CRC_POLY = 8'h07;
    // ==========================================================
    // Clock, design and host
    always #5 ref_clk = ~ref_clk;
    msecr_host HOST (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
    msecr_top DUT (
        .ref_clk(ref_clk), .arst_n(arst_n), .spi_sclk(sclk), .spi_cs_n(cs_n),
        .spi_mosi(mosi), .burst_mode(burst_mode), .round_robin_active(rr),
        .spi_miso(miso), .channel_switch(ch), .general_output_one(gpo[0]),
        .general_output_two(gpo[1]), .general_output_three(gpo[2]),
        .general_output_four(gpo[3]), .addr_err_pulse(a_p), .sclk_err_pulse(s_p),
        .crc_err_pulse(c_p)
    );
    always @(posedge ref_clk) begin
        n_a += (a_p === 1'b1);
        n_s += (s_p === 1'b1);
        n_c += (c_p === 1'b1);
    end
    // ==========================================================
    // Tasks
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        HOST.xfer({16'h0000, 1'b0, a, v}, 16, r);
    endtask : wr
    function automatic logic [7:0] crc8(input logic [15:0] m);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i]) ? CRC_POLY : 8'h00);
        end
        return c;
    endfunction : crc8
    // Checked write, x corrupts the check byte on purpose
    task automatic wrc(input logic [6:0] a, input logic [7:0] v, input logic [7:0] x);
        HOST.xfer({8'h00, 1'b0, a, v, crc8({1'b0, a, v}) ^ x}, 24, r);
    endtask : wrc
    // Readback comes out in the frame after the request
    task automatic rd(input logic [6:0] a, output logic [7:0] v);
        HOST.xfer({16'h0000, 1'b1, a, 8'h00}, 16, r);
        HOST.xfer({16'h0000, 1'b1, a, 8'h00}, 16, r);
        v = r[7:0];
    endtask : rd
    task automatic outs();
        logic [7:0] e;
        e = sw[0] ? 8'(1 << sw[3:1]) : 8'h00;
        repeat (3) @(posedge ref_clk);
        `CHK(ch, e)
        `CHK(gpo, sw[7:4])
    endtask : outs
    task automatic summarize();
        if (mismatches == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize
    // ==========================================================
    // Scenarios
    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        summarize();
    end
    initial begin
        sw = 8'h00;
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        outs();
        rd(7'h01, d);
        `CHK(d, 8'h00)
        rd(7'h02, d);
        `CHK(d, 8'h06)
        for (int i = 0; i <= 8; i++) begin
            sw = {4'($random(seed)), 3'(i), i < 8};
            wr(7'h01, sw);
            outs();
        end
        rd(7'h01, d);
        `CHK(d, sw)
        @(posedge ref_clk) rr <= 1'b1;
        repeat (3) @(posedge ref_clk);
        `CHK(gpo, 4'h0)
        @(posedge ref_clk) rr <= 1'b0;
        outs();
        wr(7'h02, 8'h02);
        rd(7'h02, d);
        `CHK(d, 8'h02)
        wr(7'h05, 8'h11);
        `CHK(n_a, 0)
        wr(7'h02, 8'h06);
        wr(7'h05, 8'h11);
        `CHK(n_a, 1)
        HOST.xfer({15'h0000, 1'b0, 7'h01, 8'h55, 1'b0}, 17, r);
        `CHK(n_s, 1)
        outs();
        wr(7'h02, 8'h04);
        HOST.xfer({15'h0000, 1'b0, 7'h01, 8'h55, 1'b0}, 17, r);
        sw = 8'h55;
        `CHK(n_s, 1)
        outs();
        wr(7'h02, 8'h06);
        @(posedge ref_clk) burst_mode <= 1'b1;
        HOST.xfer({8'h01, 8'h33, 8'h01, 8'h2d}, 32, r);
        sw = 8'h2d;
        `CHK(n_s, 1)
        outs();
        HOST.xfer({8'h00, 8'h01, 8'h4b, 8'h00}, 24, r);
        `CHK(n_s, 2)
        outs();
        @(posedge ref_clk) burst_mode <= 1'b0;
        `CHK(n_c, 0)
        wr(7'h02, 8'h07);
        wrc(7'h01, 8'h9b, 8'h00);
        sw = 8'h9b;
        outs();
        wrc(7'h01, 8'h3c, 8'hff);
        `CHK(n_c, 1)
        outs();
        wrc(7'h02, 8'h06, 8'h00);
        `CHK(n_s, 2)
        rd(7'h02, d);
        `CHK(d, 8'h06)
        summarize();
    end
endmodule : test_mux_switch_error_config_regs
